// file: hdl/scfg_bank.sv
`timescale 1ns/100ps
module scfg_bank
    import scfg_pkg::*;
#(
    parameter logic [31:0] WAKE1_SHORT_P = WAKE1_SHORT_CYC,
    parameter logic [31:0] WAKE1_LONG_P  = WAKE1_LONG_CYC,
    parameter logic [31:0] WAKE2_SHORT_P = WAKE2_SHORT_CYC,
    parameter logic [31:0] WAKE2_LONG_P  = WAKE2_LONG_CYC,
    parameter logic [31:0] RST_4_P       = RST_4_CYC,
    parameter logic [31:0] RST_8_P       = RST_8_CYC,
    parameter logic [31:0] RST_10_P      = RST_10_CYC,
    parameter logic [31:0] RST_14_P      = RST_14_CYC
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // register access from the serial port engine
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [15:0] reg_addr,
    input  wire logic [7:0]  reg_wdata,
    output logic [7:0]       reg_rdata,
    output logic             reg_rvalid,
    // pins and system status
    input  wire logic        reset_request_input_n,
    input  wire logic        external_supply_input,
    input  wire logic        hz_exit,
    output logic             reset_pulse_output_n,
    // configuration outputs
    output logic             high_impedance_entry,
    output logic             storage_entry,
    output logic             divider_ratio_30pct,
    output logic [2:0]       cell_undervoltage_threshold,
    output logic             one_shot_temp_sense,
    output logic             discharge_current_monitor_on,
    output logic             cell_divider_on,
    // hold timer events
    output logic             wake1_evt,
    output logic             wake2_evt,
    output logic             reset_evt
);
    function automatic logic hit(input logic [15:0] a,
                                 input logic [15:0] off);
        return a == off;
    endfunction
    logic        wr_sys, wr_bat, wr_mon, wr_rin, init_regs;
    logic        hz_hw_set, store_hw_set, pulse_start, pulse_allowed;
    logic [1:0]  rout_sel, rec_sel;
    logic [3:0]  pulse_cnt_reg;
    logic [7:0]  rin_reg, rd_next;
    logic [31:0] wake1_cyc, wake2_cyc, reset_cyc;
    scfg_pulse_e pulse_state_reg;

    // ****************************************
    // write decode
    // ****************************************
    assign wr_sys    = reg_wr && hit(reg_addr, ADDR_SYS_MODE);
    assign wr_bat    = reg_wr && hit(reg_addr, ADDR_BAT_THR);
    assign wr_mon    = reg_wr && hit(reg_addr, ADDR_MON_CTL);
    assign wr_rin    = reg_wr && hit(reg_addr, ADDR_RIN_TIM);
    // re-initialise wins over the rest of the same write
    assign init_regs = wr_sys && reg_wdata[SYS_INIT_BIT];
    assign rout_sel  = rin_reg[RIN_ROUT_MSB:RIN_ROUT_LSB];
    assign rec_sel   = rin_reg[RIN_REC_MSB:RIN_REC_LSB];

    // ****************************************
    // system mode register
    // ****************************************
    assign hz_hw_set    = reset_evt && (rec_sel == REC_HIZ);
    assign store_hw_set = reset_evt && (rec_sel == REC_STORE);
    // hardware set beats a software write unless it re-initialises; exit clears only when idle
    always_ff @(posedge clk) begin
        if (srst || init_regs) begin
            high_impedance_entry <= SYS_MODE_RST[SYS_HZ_BIT];
        end else if (hz_hw_set) begin
            high_impedance_entry <= 1'b1;
        end else if (wr_sys) begin
            high_impedance_entry <= reg_wdata[SYS_HZ_BIT];
        end else if (hz_exit) begin
            high_impedance_entry <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst || init_regs) begin
            storage_entry <= SYS_MODE_RST[SYS_STORE_BIT];
        end else if (store_hw_set) begin
            storage_entry <= 1'b1;
        end else if (wr_sys) begin
            storage_entry <= reg_wdata[SYS_STORE_BIT];
        end
    end

    // ****************************************
    // battery threshold and monitor registers
    // ****************************************
    always_ff @(posedge clk) begin
        if (srst || init_regs) begin
            divider_ratio_30pct         <= BAT_THR_RST[BAT_RATIO_BIT];
            cell_undervoltage_threshold <=
                BAT_THR_RST[BAT_UVLO_MSB:BAT_UVLO_LSB];
        end else if (wr_bat) begin
            divider_ratio_30pct         <= reg_wdata[BAT_RATIO_BIT];
            cell_undervoltage_threshold <=
                reg_wdata[BAT_UVLO_MSB:BAT_UVLO_LSB];
        end
    end
    always_ff @(posedge clk) begin
        if (srst || init_regs) begin
            discharge_current_monitor_on <= MON_CTL_RST[MON_IDIS_BIT];
            cell_divider_on              <= MON_CTL_RST[MON_DIV_BIT];
        end else if (wr_mon) begin
            discharge_current_monitor_on <= reg_wdata[MON_IDIS_BIT];
            cell_divider_on              <= reg_wdata[MON_DIV_BIT];
        end
    end

    // trigger bit is self-clearing: one pulse per write of 1
    always_ff @(posedge clk) begin
        if (srst) begin
            one_shot_temp_sense <= 1'b0;
        end else begin
            one_shot_temp_sense <= wr_mon && reg_wdata[MON_TS_BIT];
        end
    end

    // ****************************************
    // reset input timing register
    // ****************************************
    always_ff @(posedge clk) begin
        if (srst || init_regs) begin
            rin_reg <= RIN_TIM_RST;
        end else if (wr_rin) begin
            rin_reg <= reg_wdata;
        end
    end
    always_comb begin
        wake1_cyc = rin_reg[RIN_WAKE1_BIT] ? WAKE1_LONG_P : WAKE1_SHORT_P;
        wake2_cyc = rin_reg[RIN_WAKE2_BIT] ? WAKE2_LONG_P : WAKE2_SHORT_P;
        case (rin_reg[RIN_RST_MSB:RIN_RST_LSB])
            PER_RST_4:  reset_cyc = RST_4_P;
            PER_RST_8:  reset_cyc = RST_8_P;
            PER_RST_10: reset_cyc = RST_10_P;
            default:    reset_cyc = RST_14_P;
        endcase
    end
    scfg_rin_timer u_timer (
        .clk       (clk),
        .srst      (srst),
        .rin_low   (!reset_request_input_n),
        .wake1_cyc (wake1_cyc),
        .wake2_cyc (wake2_cyc),
        .reset_cyc (reset_cyc),
        .wake1_evt (wake1_evt),
        .wake2_evt (wake2_evt),
        .reset_evt (reset_evt)
    );

    // ****************************************
    // reset pulse output
    // ****************************************
    always_comb begin
        case (rout_sel)
            ROUT_ON:     pulse_allowed = 1'b1;
            ROUT_SUPPLY: pulse_allowed = external_supply_input;
            default:     pulse_allowed = 1'b0;
        endcase
    end
    // a new expiry during a pulse is absorbed, not stretched
    assign pulse_start = reset_evt && pulse_allowed &&
                         (pulse_state_reg == SCFG_PL_IDLE);
    always_ff @(posedge clk) begin
        if (srst) begin
            pulse_state_reg      <= SCFG_PL_IDLE;
            pulse_cnt_reg        <= 4'h0;
            reset_pulse_output_n <= 1'b1;
        end else begin
            case (pulse_state_reg)
                SCFG_PL_IDLE: begin
                    if (pulse_start) begin
                        pulse_state_reg      <= SCFG_PL_DRIVE;
                        pulse_cnt_reg        <= ROUT_PULSE_CYC - 4'h1;
                        reset_pulse_output_n <= 1'b0;
                    end
                end
                SCFG_PL_DRIVE: begin
                    if (pulse_cnt_reg == 4'h0) begin
                        pulse_state_reg      <= SCFG_PL_IDLE;
                        reset_pulse_output_n <= 1'b1;
                    end else begin
                        pulse_cnt_reg <= pulse_cnt_reg - 4'h1;
                    end
                end
                default: begin
                    pulse_state_reg      <= SCFG_PL_IDLE;
                    reset_pulse_output_n <= 1'b1;
                end
            endcase
        end
    end

    // ****************************************
    // read path
    // ****************************************
    always_comb begin
        rd_next = UNMAPPED_RD;
        if (hit(reg_addr, ADDR_SYS_MODE)) begin
            rd_next = SYS_MODE_RST & (8'h01 << SYS_ONE_BIT);
            rd_next[SYS_HZ_BIT]    = high_impedance_entry;
            rd_next[SYS_STORE_BIT] = storage_entry;
        end else if (hit(reg_addr, ADDR_BAT_THR)) begin
            rd_next[BAT_RATIO_BIT] = divider_ratio_30pct;
            rd_next[BAT_UVLO_MSB:BAT_UVLO_LSB] = cell_undervoltage_threshold;
        end else if (hit(reg_addr, ADDR_MON_CTL)) begin
            rd_next[MON_IDIS_BIT] = discharge_current_monitor_on;
            rd_next[MON_DIV_BIT]  = cell_divider_on;
        end else if (hit(reg_addr, ADDR_RIN_TIM)) begin
            rd_next = rin_reg;
        end
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= rd_next;
            end
        end
    end

    // ****************************************
    // checks
    // ****************************************
    property p_hz_exit;
        @(posedge clk) disable iff (srst)
        hz_exit && !wr_sys && !hz_hw_set |=> !high_impedance_entry;
    endproperty
    a_hz_exit: assert property (p_hz_exit)
        else $error("hz bit not cleared on exit");
    property p_ratio;
        @(posedge clk) disable iff (srst)
        wr_bat |=> divider_ratio_30pct == $past(reg_wdata[BAT_RATIO_BIT]);
    endproperty
    a_ratio: assert property (p_ratio)
        else $error("divider ratio not taken from write");
    property p_ts_once;
        @(posedge clk) disable iff (srst)
        wr_mon && reg_wdata[MON_TS_BIT] |=> one_shot_temp_sense ##1
            (!one_shot_temp_sense || $past(wr_mon && reg_wdata[MON_TS_BIT]));
    endproperty
    a_ts_once: assert property (p_ts_once)
        else $error("temperature trigger not a single pulse");
    property p_pulse_len;
        @(posedge clk) disable iff (srst)
        pulse_start |=> !reset_pulse_output_n [*8] ##1 reset_pulse_output_n;
    endproperty
    a_pulse_len: assert property (p_pulse_len)
        else $error("reset pulse length wrong");
    property p_pulse_off;
        @(posedge clk) disable iff (srst)
        reset_evt && reset_pulse_output_n &&
        (rout_sel == ROUT_OFF || rout_sel == 2'h3) |=> reset_pulse_output_n;
    endproperty
    a_pulse_off: assert property (p_pulse_off)
        else $error("reset pulse driven while disabled");
    property p_supply_gate;
        @(posedge clk) disable iff (srst)
        reset_evt && reset_pulse_output_n && rout_sel == ROUT_SUPPLY
            |=> reset_pulse_output_n == !$past(external_supply_input);
    endproperty
    a_supply_gate: assert property (p_supply_gate)
        else $error("supply-gated pulse wrong");
    property p_expiry_hiz;
        @(posedge clk) disable iff (srst)
        reset_evt && rec_sel == REC_HIZ && !init_regs
            |=> high_impedance_entry;
    endproperty
    a_expiry_hiz: assert property (p_expiry_hiz)
        else $error("expiry did not enter high impedance");
    property p_expiry_unused;
        @(posedge clk) disable iff (srst)
        reset_evt && (rec_sel == REC_UNUSED || rec_sel == 2'h3) &&
        !wr_sys && !hz_exit
            |=> $stable(storage_entry) && $stable(high_impedance_entry);
    endproperty
    a_expiry_unused: assert property (p_expiry_unused)
        else $error("unused transition changed mode");
endmodule // scfg_bank

// file: hdl/scfg_pkg.sv
package scfg_pkg;

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [15:0] ADDR_SYS_MODE = 16'h000D;
    localparam logic [15:0] ADDR_BAT_THR  = 16'h000E;
    localparam logic [15:0] ADDR_MON_CTL  = 16'h000F;
    localparam logic [15:0] ADDR_RIN_TIM  = 16'h0010;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0] SYS_MODE_RST = 8'h04;
    localparam logic [7:0] BAT_THR_RST  = 8'h06;
    localparam logic [7:0] MON_CTL_RST  = 8'h00;
    localparam logic [7:0] RIN_TIM_RST  = 8'h66;
    localparam logic [7:0] UNMAPPED_RD  = 8'h00;

    // ****************************************
    // field positions
    // ****************************************
    localparam int SYS_INIT_BIT  = 7;
    localparam int SYS_ONE_BIT   = 2;
    localparam int SYS_HZ_BIT    = 1;
    localparam int SYS_STORE_BIT = 0;
    localparam int BAT_RATIO_BIT = 4;
    localparam int BAT_UVLO_MSB  = 2;
    localparam int BAT_UVLO_LSB  = 0;
    localparam int MON_TS_BIT    = 4;
    localparam int MON_IDIS_BIT  = 1;
    localparam int MON_DIV_BIT   = 0;
    localparam int RIN_RST_MSB   = 7;
    localparam int RIN_RST_LSB   = 6;
    localparam int RIN_WAKE2_BIT = 5;
    localparam int RIN_WAKE1_BIT = 4;
    localparam int RIN_ROUT_MSB  = 3;
    localparam int RIN_ROUT_LSB  = 2;
    localparam int RIN_REC_MSB   = 1;
    localparam int RIN_REC_LSB   = 0;

    // ****************************************
    // field encodings
    // ****************************************
    localparam logic [1:0] ROUT_OFF    = 2'h0;
    localparam logic [1:0] ROUT_ON     = 2'h1;
    localparam logic [1:0] ROUT_SUPPLY = 2'h2;
    localparam logic [1:0] REC_UNUSED  = 2'h0;
    localparam logic [1:0] REC_STORE   = 2'h1;
    localparam logic [1:0] REC_HIZ     = 2'h2;
    localparam logic [1:0] PER_RST_4   = 2'h0;
    localparam logic [1:0] PER_RST_8   = 2'h1;
    localparam logic [1:0] PER_RST_10  = 2'h2;

    typedef enum logic {
        SCFG_PL_IDLE  = 1'b0,
        SCFG_PL_DRIVE = 1'b1
    } scfg_pulse_e;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_KHZ        = 125000;
    localparam int CLK_PERIOD_NS  = 8;
    localparam int WAKE1_SHORT_MS = 50;
    localparam int WAKE1_LONG_MS  = 500;
    localparam int WAKE2_SHORT_MS = 1000;
    localparam int WAKE2_LONG_MS  = 1500;
    localparam int RST_4_MS       = 4000;
    localparam int RST_8_MS       = 8000;
    localparam int RST_10_MS      = 10000;
    localparam int RST_14_MS      = 14000;
    localparam int ROUT_PULSE_NS  = 64;

    localparam logic [31:0] WAKE1_SHORT_CYC = 32'(WAKE1_SHORT_MS * CLK_KHZ);
    localparam logic [31:0] WAKE1_LONG_CYC  = 32'(WAKE1_LONG_MS * CLK_KHZ);
    localparam logic [31:0] WAKE2_SHORT_CYC = 32'(WAKE2_SHORT_MS * CLK_KHZ);
    localparam logic [31:0] WAKE2_LONG_CYC  = 32'(WAKE2_LONG_MS * CLK_KHZ);
    localparam logic [31:0] RST_4_CYC       = 32'(RST_4_MS * CLK_KHZ);
    localparam logic [31:0] RST_8_CYC       = 32'(RST_8_MS * CLK_KHZ);
    localparam logic [31:0] RST_10_CYC      = 32'(RST_10_MS * CLK_KHZ);
    localparam logic [31:0] RST_14_CYC      = 32'(RST_14_MS * CLK_KHZ);
    localparam logic [3:0]  ROUT_PULSE_CYC  =
        4'((ROUT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

endpackage

// file: hdl/scfg_rin_timer.sv
`timescale 1ns/100ps
module scfg_rin_timer
    import scfg_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // request level and periods
    input  wire logic        rin_low,
    input  wire logic [31:0] wake1_cyc,
    input  wire logic [31:0] wake2_cyc,
    input  wire logic [31:0] reset_cyc,
    // one-cycle expiry events
    output logic             wake1_evt,
    output logic             wake2_evt,
    output logic             reset_evt
);

    logic [31:0] hold_cnt_reg;

    // ****************************************
    // low-level hold counter
    // ****************************************
    // saturates so a stuck-low input cannot wrap and fire twice
    always_ff @(posedge clk) begin
        if (srst || !rin_low) begin
            hold_cnt_reg <= '0;
        end else if (hold_cnt_reg != 32'hFFFFFFFF) begin
            hold_cnt_reg <= hold_cnt_reg + 32'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wake1_evt <= 1'b0;
            wake2_evt <= 1'b0;
            reset_evt <= 1'b0;
        end else begin
            wake1_evt <= rin_low && (hold_cnt_reg == wake1_cyc - 32'h1);
            wake2_evt <= rin_low && (hold_cnt_reg == wake2_cyc - 32'h1);
            reset_evt <= rin_low && (hold_cnt_reg == reset_cyc - 32'h1);
        end
    end

    property p_hold_fire;
        @(posedge clk) disable iff (srst)
        rin_low && (hold_cnt_reg == reset_cyc - 32'h1)
            |=> reset_evt && (hold_cnt_reg == $past(reset_cyc));
    endproperty
    a_hold_fire: assert property (p_hold_fire)
        else $error("reset hold expiry not flagged on time");

    property p_release_clears;
        @(posedge clk) disable iff (srst)
        !rin_low |=> hold_cnt_reg == 32'h0 && !wake1_evt && !wake2_evt;
    endproperty
    a_release_clears: assert property (p_release_clears)
        else $error("hold count survived release of the request");

endmodule // scfg_rin_timer

// file: test/scfg_bank_tb_top.sv
`timescale 1ns/100ps
module scfg_bank_tb_top;
    import scfg_pkg::*;

    // ****************************************
    // stimulus and observed signals
    // ****************************************
    logic        clk;
    logic        srst;
    logic        reg_wr;
    logic        reg_rd;
    logic [15:0] reg_addr;
    logic [7:0]  reg_wdata;
    logic [7:0]  reg_rdata;
    logic        reg_rvalid;
    logic        reset_request_input_n;
    logic        external_supply_input;
    logic        hz_exit;
    logic        reset_pulse_output_n;
    logic        high_impedance_entry;
    logic        storage_entry;
    logic        divider_ratio_30pct;
    logic [2:0]  cell_undervoltage_threshold;
    logic        one_shot_temp_sense;
    logic        discharge_current_monitor_on;
    logic        cell_divider_on;
    logic        wake1_evt;
    logic        wake2_evt;
    logic        reset_evt;
    int          fails;
    int          check_count;
    logic [7:0]  exp_q[$];
    logic [7:0]  cfgs[5] = '{8'h66, 8'hD9, 8'h18, 8'hAF, 8'h50};
    logic        sups[5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
    logic [7:0]  rnd;

    // short periods keep the run small; expectations use the same figures
    localparam logic [31:0] TB_W1_SHORT = 32'd10;
    localparam logic [31:0] TB_W1_LONG  = 32'd20;
    localparam logic [31:0] TB_W2_SHORT = 32'd30;
    localparam logic [31:0] TB_W2_LONG  = 32'd40;
    localparam logic [31:0] TB_RST_4    = 32'd50;
    localparam logic [31:0] TB_RST_8    = 32'd60;
    localparam logic [31:0] TB_RST_10   = 32'd70;
    localparam logic [31:0] TB_RST_14   = 32'd80;

    scfg_bank #(
        .WAKE1_SHORT_P (TB_W1_SHORT),
        .WAKE1_LONG_P  (TB_W1_LONG),
        .WAKE2_SHORT_P (TB_W2_SHORT),
        .WAKE2_LONG_P  (TB_W2_LONG),
        .RST_4_P       (TB_RST_4),
        .RST_8_P       (TB_RST_8),
        .RST_10_P      (TB_RST_10),
        .RST_14_P      (TB_RST_14)
    ) dut (
        .clk                          (clk),
        .srst                         (srst),
        .reg_wr                       (reg_wr),
        .reg_rd                       (reg_rd),
        .reg_addr                     (reg_addr),
        .reg_wdata                    (reg_wdata),
        .reg_rdata                    (reg_rdata),
        .reg_rvalid                   (reg_rvalid),
        .reset_request_input_n        (reset_request_input_n),
        .external_supply_input        (external_supply_input),
        .hz_exit                      (hz_exit),
        .reset_pulse_output_n         (reset_pulse_output_n),
        .high_impedance_entry         (high_impedance_entry),
        .storage_entry                (storage_entry),
        .divider_ratio_30pct          (divider_ratio_30pct),
        .cell_undervoltage_threshold  (cell_undervoltage_threshold),
        .one_shot_temp_sense          (one_shot_temp_sense),
        .discharge_current_monitor_on (discharge_current_monitor_on),
        .cell_divider_on              (cell_divider_on),
        .wake1_evt                    (wake1_evt),
        .wake2_evt                    (wake2_evt),
        .reset_evt                    (reset_evt)
    );

    // ****************************************
    // clock, checking and bus tasks
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [7:0] seen,
                         input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        reg_wr    = 1'b1;
        reg_addr  = a;
        reg_wdata = d;
        @(posedge clk);
        #1;
        reg_wr = 1'b0;
    endtask

    // expectation noted here, compared when the read data shows up
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        exp_q.push_back(exp);
        @(posedge clk);
        #1;
        reg_rd   = 1'b1;
        reg_addr = a;
        @(posedge clk);
        #1;
        reg_rd = 1'b0;
    endtask

    always @(posedge clk) begin
        if (reg_rvalid === 1'b1) begin
            if (exp_q.size() == 0) begin
                fails++;
                $display("wrong value reg_rdata expected none seen %h",
                         reg_rdata);
            end else begin
                check("reg_rdata", reg_rdata, exp_q.pop_front());
            end
        end
    end

    task automatic rd_por();
        rd(ADDR_SYS_MODE, 8'h04);
        rd(ADDR_BAT_THR, 8'h06);
        rd(ADDR_MON_CTL, 8'h00);
        rd(ADDR_RIN_TIM, 8'h66);
    endtask

    // pin held low long enough for all three expiries plus the pulse
    task automatic hold(input logic [7:0] cfg, input logic sup);
        int   w1t, w2t, rt, w1n, w2n, rn, lows, per;
        logic pulse, to_st, to_hz;
        per   = 50 + 10 * int'(cfg[7:6]);
        pulse = (cfg[3:2] == ROUT_ON) || (cfg[3:2] == ROUT_SUPPLY && sup);
        to_st = cfg[1:0] == REC_STORE;
        to_hz = cfg[1:0] == REC_HIZ;
        {w1t, w2t, rt, w1n, w2n, rn, lows} = '0;
        wr(ADDR_SYS_MODE, 8'h00);
        wr(ADDR_RIN_TIM, cfg);
        external_supply_input = sup;
        reset_request_input_n = 1'b0;
        for (int i = 1; i <= per + 12; i++) begin
            @(posedge clk);
            #1;
            if (wake1_evt === 1'b1) begin w1n++; w1t = i; end
            if (wake2_evt === 1'b1) begin w2n++; w2t = i; end
            if (reset_evt === 1'b1) begin rn++; rt = i; end
            if (reset_pulse_output_n === 1'b0) lows++;
        end
        reset_request_input_n = 1'b1;
        check("first wake time", 8'(w1t), cfg[4] ? 8'd20 : 8'd10);
        check("second wake time", 8'(w2t), cfg[5] ? 8'd40 : 8'd30);
        check("reset time", 8'(rt), 8'(per));
        check("event counts", 8'(w1n + w2n + rn), 8'd3);
        check("pulse low", 8'(lows), pulse ? 8'd8 : 8'd0);
        check("storage", 8'(storage_entry), 8'(to_st));
        check("hi z", 8'(high_impedance_entry), 8'(to_hz));
        rd(ADDR_RIN_TIM, cfg);
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        srst = 1'b1;
        {reg_wr, reg_rd, hz_exit} = 3'h0;
        reg_addr = 16'h0000;
        reg_wdata = 8'h00;
        reset_request_input_n = 1'b1;
        external_supply_input = 1'b0;
        fails = 0;
        check_count = 0;
        rnd = 8'($urandom(32'h9661));
        repeat (4) @(posedge clk);
        #1;
        srst = 1'b0;
        rd_por();
        rd(16'h0011, UNMAPPED_RD);
        check("ratio", 8'(divider_ratio_30pct), 8'h00);
        check("uvlo", 8'(cell_undervoltage_threshold), 8'h06);
        wr(ADDR_MON_CTL, 8'h13);
        check("temp sense", 8'(one_shot_temp_sense), 8'h01);
        check("idis", 8'(discharge_current_monitor_on), 8'h01);
        check("divider on", 8'(cell_divider_on), 8'h01);
        @(posedge clk);
        #1;
        check("temp sense end", 8'(one_shot_temp_sense), 8'h00);
        rd(ADDR_MON_CTL, 8'h03);
        for (int k = 0; k < 4; k++) begin
            rnd = 8'($urandom);
            wr(ADDR_BAT_THR, rnd);
            check("ratio", 8'(divider_ratio_30pct), 8'(rnd[4]));
            check("uvlo", 8'(cell_undervoltage_threshold), 8'(rnd[2:0]));
            rd(ADDR_BAT_THR, rnd & 8'h17);
        end
        wr(ADDR_SYS_MODE, 8'h02);
        check("hi z set", 8'(high_impedance_entry), 8'h01);
        rd(ADDR_SYS_MODE, 8'h06);
        hz_exit = 1'b1;
        @(posedge clk);
        #1;
        hz_exit = 1'b0;
        check("hi z cleared", 8'(high_impedance_entry), 8'h00);
        wr(ADDR_SYS_MODE, 8'h01);
        check("storage set", 8'(storage_entry), 8'h01);
        rd(ADDR_SYS_MODE, 8'h05);
        wr(16'h0011, 8'hFF);
        rd(16'h0011, UNMAPPED_RD);
        for (int k = 0; k < 5; k++) hold(cfgs[k], sups[k]);
        wr(ADDR_RIN_TIM, 8'h00);
        wr(ADDR_BAT_THR, 8'h11);
        wr(ADDR_SYS_MODE, 8'h83);
        check("init storage", 8'(storage_entry), 8'h00);
        check("init hi z", 8'(high_impedance_entry), 8'h00);
        rd_por();
        repeat (3) @(posedge clk);
        if (exp_q.size() != 0) begin
            fails++;
            $display("wrong value read count expected 0 seen %0d",
                     exp_q.size());
        end
        test_done();
    end

    // hang guard
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        test_done();
    end

endmodule // scfg_bank_tb_top
